// >>> core/ccwa_pkg.sv
package ccwa_pkg;

    // Bus placement and register byte offsets
    localparam logic [31:0] CCWA_BASE_ADDR = 32'h4000_5000;
    localparam int CCWA_AW = 12;
    localparam logic [11:0] CCWA_OFS_SECONDS = 12'h000;
    localparam logic [11:0] CCWA_OFS_MINUTES = 12'h004;
    localparam logic [11:0] CCWA_OFS_HOURS = 12'h008;
    localparam logic [11:0] CCWA_OFS_WEEKDAY = 12'h00C;
    localparam logic [11:0] CCWA_OFS_DAY = 12'h010;
    localparam logic [11:0] CCWA_OFS_MONTH = 12'h014;
    localparam logic [11:0] CCWA_OFS_YEAR = 12'h018;
    localparam logic [11:0] CCWA_OFS_CONTROL = 12'h01C;
    localparam logic [11:0] CCWA_OFS_AL0_MINUTE = 12'h020;
    localparam logic [11:0] CCWA_OFS_AL0_HOUR = 12'h024;
    localparam logic [11:0] CCWA_OFS_AL0_WEEKDAY = 12'h028;
    localparam logic [11:0] CCWA_OFS_AL1_MINUTE = 12'h02C;
    localparam logic [11:0] CCWA_OFS_AL1_HOUR = 12'h030;
    localparam logic [11:0] CCWA_OFS_AL1_DAY = 12'h034;
    localparam logic [11:0] CCWA_OFS_AL1_MONTH = 12'h038;
    localparam logic [11:0] CCWA_OFS_TIME_SNAP = 12'h050;
    localparam logic [11:0] CCWA_OFS_DATE_SNAP = 12'h054;
    localparam logic [11:0] CCWA_OFS_IRQ_STATUS = 12'h060;

    // Field widths
    localparam int CCWA_W_SEC = 7;
    localparam int CCWA_W_MIN = 7;
    localparam int CCWA_W_HOUR = 6;
    localparam int CCWA_W_WEEK = 3;
    localparam int CCWA_W_DAY = 6;
    localparam int CCWA_W_MONTH = 5;
    localparam int CCWA_W_YEAR = 8;

    // Counting ranges, BCD
    localparam logic [7:0] CCWA_SEC_MAX = 8'h59;
    localparam logic [7:0] CCWA_MIN_MAX = 8'h59;
    localparam logic [7:0] CCWA_HOUR_MAX = 8'h23;
    localparam logic [7:0] CCWA_WEEK_MIN = 8'h01;
    localparam logic [7:0] CCWA_WEEK_MAX = 8'h07;
    localparam logic [7:0] CCWA_DAY_MIN = 8'h01;
    localparam logic [7:0] CCWA_MONTH_MIN = 8'h01;
    localparam logic [7:0] CCWA_MONTH_MAX = 8'h12;
    localparam logic [7:0] CCWA_YEAR_MAX = 8'h99;
    localparam logic [7:0] CCWA_ZERO_MIN = 8'h00;
    localparam logic [7:0] CCWA_DAYS_31 = 8'h31;
    localparam logic [7:0] CCWA_DAYS_30 = 8'h30;
    localparam logic [7:0] CCWA_DAYS_29 = 8'h29;
    localparam logic [7:0] CCWA_DAYS_28 = 8'h28;

    // Reset values
    localparam logic [7:0] CCWA_RST_WEEK = 8'h07;
    localparam logic [7:0] CCWA_RST_DAY = 8'h01;
    localparam logic [7:0] CCWA_RST_MONTH = 8'h01;
    localparam logic [7:0] CCWA_RST_ZERO = 8'h00;

    // Control register fields
    localparam int CCWA_CTL_RUN = 0;
    localparam int CCWA_CTL_PSEL_LO = 1;
    localparam int CCWA_CTL_AL0_EN = 3;
    localparam int CCWA_CTL_AL1_EN = 4;
    localparam int CCWA_CTL_W = 5;

    // Interrupt status fields
    localparam int CCWA_ST_PERIODIC = 0;
    localparam int CCWA_ST_ALARM0 = 1;
    localparam int CCWA_ST_ALARM1 = 2;
    localparam int CCWA_ST_W = 3;

    // Time base: low-speed source rate in ticks per second
    localparam int CCWA_LS_TICKS_PER_SEC = 32768;

    typedef enum logic [1:0] {
        CCWA_PER_OFF,
        CCWA_PER_HALF_SEC,
        CCWA_PER_ONE_SEC,
        CCWA_PER_ONE_MIN
    } ccwa_period_t;

    typedef struct packed {
        logic [CCWA_W_YEAR-1:0] year;
        logic [CCWA_W_MONTH-1:0] month;
        logic [CCWA_W_DAY-1:0] day;
        logic [CCWA_W_WEEK-1:0] weekday;
        logic [CCWA_W_HOUR-1:0] hour;
        logic [CCWA_W_MIN-1:0] minute;
        logic [CCWA_W_SEC-1:0] second;
    } ccwa_time_t;

endpackage : ccwa_pkg

// >>> core/ccwa_prescaler.sv
`timescale 1ns/1ps
module ccwa_prescaler
    import ccwa_pkg::*;
#(
    parameter int DIV = CCWA_LS_TICKS_PER_SEC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic low_speed_tick,
    input wire logic clear,
    output logic half_pulse,
    output logic full_pulse
);

    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] HALF = CW'(DIV / 2 - 1);

    typedef struct packed {
        logic [CW-1:0] count;
    } ccwa_pre_state_t;

    ccwa_pre_state_t q;
    ccwa_pre_state_t next_q;

    // One full period after a clear before the next second tick
    always_comb begin
        next_q = q;
        if (clear) begin
            next_q.count = '0;
        end else if (low_speed_tick) begin
            next_q.count = (q.count == LAST) ? '0 : q.count + CW'(1);
        end
    end

    assign full_pulse = ce && !clear && low_speed_tick && (q.count == LAST);
    assign half_pulse = ce && !clear && low_speed_tick && ((q.count == LAST) || (q.count == HALF));

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= next_q;
        end
    end

endmodule : ccwa_prescaler

// >>> core/ccwa_bcd_counter.sv
`timescale 1ns/1ps
module ccwa_bcd_counter
    import ccwa_pkg::*;
#(
    parameter int W = 7,
    parameter logic [7:0] MIN = 8'h00,
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic inc,
    input wire logic load,
    input wire logic [W-1:0] load_value,
    input wire logic [7:0] max_value,
    output logic [W-1:0] value,
    output logic carry
);

    typedef struct packed {
        logic [W-1:0] value;
    } ccwa_cnt_state_t;

    ccwa_cnt_state_t q;
    ccwa_cnt_state_t next_q;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_inc

    logic at_max;
    assign at_max = (8'(q.value) == max_value);
    // A software load suppresses the carry it would otherwise pass on
    assign carry = ce && inc && !load && at_max;
    assign value = q.value;

    always_comb begin
        next_q = q;
        if (load) begin
            next_q.value = load_value;
        end else if (inc) begin
            next_q.value = at_max ? W'(MIN) : W'(bcd_inc(8'(q.value)));
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q.value <= W'(RESET_VALUE);
        end else if (ce) begin
            q <= next_q;
        end
    end

endmodule : ccwa_bcd_counter

// >>> core/ccwa_calendar_clock.sv
// Behaviour
// - Seconds: BCD 00..59 in bits 6:0, software read/write.
// - While running, seconds advance on each one-hertz tick.
// - Writing seconds or minutes restarts the time base prescaler.
// - Minutes: BCD 00..59 in bits 6:0, software read/write.
// - Seconds wrapping 59 to 00 advance minutes.
// - Counters reset only by power-on reset.
// - Register map: time/date 00..18, control 1C, alarms 20..38, status 60.
// - Power-on: weekday 7, day and month 1, all else zero.
// - Read-only time view at 50, date view at 54 reset 0x0001_0107.
// - Periodic event every half second, one second or one minute.
// - Alarm 0 fires on weekday, hour and minute match.
// - Alarm 1 fires on month, day, hour and minute match.
// - Day rollover follows month length with leap-year February.
// - Hours: BCD 00..23, advance on minute wrap.
// - Weekday 1..7, advances on hour wrap.
// - Day: BCD 01..31, advances on hour wrap.
`timescale 1ns/1ps
module ccwa_calendar_clock
    import ccwa_pkg::*;
#(
    parameter int PRESCALE_DIV = CCWA_LS_TICKS_PER_SEC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic low_speed_tick,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CCWA_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic periodic_event,
    output logic alarm0_event,
    output logic alarm1_event
);

    typedef struct packed {
        logic [CCWA_CTL_W-1:0] control;
        logic [CCWA_W_MIN-1:0] al0_minute;
        logic [CCWA_W_HOUR-1:0] al0_hour;
        logic [CCWA_W_WEEK-1:0] al0_weekday;
        logic [CCWA_W_MIN-1:0] al1_minute;
        logic [CCWA_W_HOUR-1:0] al1_hour;
        logic [CCWA_W_DAY-1:0] al1_day;
        logic [CCWA_W_MONTH-1:0] al1_month;
        logic [CCWA_ST_W-1:0] status;
        logic al0_match_prev;
        logic al1_match_prev;
        logic periodic_event;
        logic alarm0_event;
        logic alarm1_event;
        logic [31:0] rdata;
    } ccwa_state_t;

    ccwa_state_t q;
    ccwa_state_t next_q;
    ccwa_time_t now;

    logic access;
    logic wr;
    logic clock_run_enable;
    ccwa_period_t period_sel;
    logic half_pulse;
    logic full_pulse;
    logic prescaler_clear;
    logic sec_inc;
    logic sec_carry;
    logic min_carry;
    logic hour_carry;
    logic week_carry;
    logic day_carry;
    logic month_carry;
    logic year_carry;
    logic leap_year;
    logic [7:0] days_in_month;
    logic wr_sec;
    logic wr_min;
    logic wr_hour;
    logic wr_week;
    logic wr_day;
    logic wr_month;
    logic wr_year;
    logic mapped;
    logic read_only;
    logic periodic_hit;
    logic al0_match;
    logic al1_match;
    logic [31:0] read_word;

    assign clock_run_enable = q.control[CCWA_CTL_RUN];
    assign period_sel = ccwa_period_t'(q.control[CCWA_CTL_PSEL_LO +: 2]);

    // APB: zero wait states, so every access phase completes at once
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign pready = 1'b1;

    always_comb begin
        mapped = 1'b1;
        read_only = 1'b0;
        case (paddr)
            CCWA_OFS_SECONDS, CCWA_OFS_MINUTES, CCWA_OFS_HOURS, CCWA_OFS_WEEKDAY,
            CCWA_OFS_DAY, CCWA_OFS_MONTH, CCWA_OFS_YEAR, CCWA_OFS_CONTROL,
            CCWA_OFS_AL0_MINUTE, CCWA_OFS_AL0_HOUR, CCWA_OFS_AL0_WEEKDAY,
            CCWA_OFS_AL1_MINUTE, CCWA_OFS_AL1_HOUR, CCWA_OFS_AL1_DAY,
            CCWA_OFS_AL1_MONTH, CCWA_OFS_IRQ_STATUS: mapped = 1'b1;
            CCWA_OFS_TIME_SNAP, CCWA_OFS_DATE_SNAP: read_only = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = access && (!mapped || (pwrite && read_only));

    assign wr_sec = wr && (paddr == CCWA_OFS_SECONDS);
    assign wr_min = wr && (paddr == CCWA_OFS_MINUTES);
    assign wr_hour = wr && (paddr == CCWA_OFS_HOURS);
    assign wr_week = wr && (paddr == CCWA_OFS_WEEKDAY);
    assign wr_day = wr && (paddr == CCWA_OFS_DAY);
    assign wr_month = wr && (paddr == CCWA_OFS_MONTH);
    assign wr_year = wr && (paddr == CCWA_OFS_YEAR);

    // Any time or date write restarts the prescaler
    assign prescaler_clear = wr_sec || wr_min || wr_hour || wr_week || wr_day || wr_month || wr_year;

    ccwa_prescaler #(
        .DIV(PRESCALE_DIV)
    ) u_prescaler (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .low_speed_tick(low_speed_tick),
        .clear(prescaler_clear),
        .half_pulse(half_pulse),
        .full_pulse(full_pulse)
    );

    assign sec_inc = clock_run_enable && full_pulse;

    // Leap year when the two-digit BCD year divides by four
    assign leap_year = now.year[4] ? (now.year[3:0] == 4'h2 || now.year[3:0] == 4'h6)
                                   : (now.year[3:0] == 4'h0 || now.year[3:0] == 4'h4
                                      || now.year[3:0] == 4'h8);

    always_comb begin
        case (now.month)
            5'h02: days_in_month = leap_year ? CCWA_DAYS_29 : CCWA_DAYS_28;
            5'h04, 5'h06, 5'h09, 5'h11: days_in_month = CCWA_DAYS_30;
            default: days_in_month = CCWA_DAYS_31;
        endcase
    end

    // Each counter's load keeps only its own field, upper bits dropped
    ccwa_bcd_counter #(.W(CCWA_W_SEC), .MIN(CCWA_ZERO_MIN), .RESET_VALUE(CCWA_RST_ZERO)) u_sec (
        .clock(clock), .rst(rst), .ce(ce),
        .inc(sec_inc),
        .load(wr_sec),
        .load_value(pwdata[CCWA_W_SEC-1:0]),
        .max_value(CCWA_SEC_MAX),
        .value(now.second),
        .carry(sec_carry)
    );

    ccwa_bcd_counter #(.W(CCWA_W_MIN), .MIN(CCWA_ZERO_MIN), .RESET_VALUE(CCWA_RST_ZERO)) u_min (
        .clock(clock), .rst(rst), .ce(ce),
        .inc(sec_carry),
        .load(wr_min),
        .load_value(pwdata[CCWA_W_MIN-1:0]),
        .max_value(CCWA_MIN_MAX),
        .value(now.minute),
        .carry(min_carry)
    );

    ccwa_bcd_counter #(.W(CCWA_W_HOUR), .MIN(CCWA_ZERO_MIN), .RESET_VALUE(CCWA_RST_ZERO)) u_hour (
        .clock(clock), .rst(rst), .ce(ce),
        .inc(min_carry),
        .load(wr_hour),
        .load_value(pwdata[CCWA_W_HOUR-1:0]),
        .max_value(CCWA_HOUR_MAX),
        .value(now.hour),
        .carry(hour_carry)
    );

    ccwa_bcd_counter #(.W(CCWA_W_WEEK), .MIN(CCWA_WEEK_MIN), .RESET_VALUE(CCWA_RST_WEEK)) u_week (
        .clock(clock), .rst(rst), .ce(ce),
        .inc(hour_carry),
        .load(wr_week),
        .load_value(pwdata[CCWA_W_WEEK-1:0]),
        .max_value(CCWA_WEEK_MAX),
        .value(now.weekday),
        .carry(week_carry)
    );

    ccwa_bcd_counter #(.W(CCWA_W_DAY), .MIN(CCWA_DAY_MIN), .RESET_VALUE(CCWA_RST_DAY)) u_day (
        .clock(clock), .rst(rst), .ce(ce),
        .inc(hour_carry),
        .load(wr_day),
        .load_value(pwdata[CCWA_W_DAY-1:0]),
        .max_value(days_in_month),
        .value(now.day),
        .carry(day_carry)
    );

    ccwa_bcd_counter #(.W(CCWA_W_MONTH), .MIN(CCWA_MONTH_MIN), .RESET_VALUE(CCWA_RST_MONTH)) u_month (
        .clock(clock), .rst(rst), .ce(ce),
        .inc(day_carry),
        .load(wr_month),
        .load_value(pwdata[CCWA_W_MONTH-1:0]),
        .max_value(CCWA_MONTH_MAX),
        .value(now.month),
        .carry(month_carry)
    );

    // Year wraps 99 to 00; its carry goes nowhere
    ccwa_bcd_counter #(.W(CCWA_W_YEAR), .MIN(CCWA_ZERO_MIN), .RESET_VALUE(CCWA_RST_ZERO)) u_year (
        .clock(clock), .rst(rst), .ce(ce),
        .inc(month_carry),
        .load(wr_year),
        .load_value(pwdata[CCWA_W_YEAR-1:0]),
        .max_value(CCWA_YEAR_MAX),
        .value(now.year),
        .carry(year_carry)
    );

    always_comb begin
        case (period_sel)
            CCWA_PER_HALF_SEC: periodic_hit = clock_run_enable && half_pulse;
            CCWA_PER_ONE_SEC: periodic_hit = sec_inc;
            CCWA_PER_ONE_MIN: periodic_hit = sec_carry;
            default: periodic_hit = 1'b0;
        endcase
    end

    assign al0_match = q.control[CCWA_CTL_AL0_EN] && (now.weekday == q.al0_weekday)
                       && (now.hour == q.al0_hour) && (now.minute == q.al0_minute);
    assign al1_match = q.control[CCWA_CTL_AL1_EN] && (now.month == q.al1_month) && (now.day == q.al1_day)
                       && (now.hour == q.al1_hour) && (now.minute == q.al1_minute);

    always_comb begin
        read_word = 32'h0000_0000;
        case (paddr)
            CCWA_OFS_SECONDS: read_word[CCWA_W_SEC-1:0] = now.second;
            CCWA_OFS_MINUTES: read_word[CCWA_W_MIN-1:0] = now.minute;
            CCWA_OFS_HOURS: read_word[CCWA_W_HOUR-1:0] = now.hour;
            CCWA_OFS_WEEKDAY: read_word[CCWA_W_WEEK-1:0] = now.weekday;
            CCWA_OFS_DAY: read_word[CCWA_W_DAY-1:0] = now.day;
            CCWA_OFS_MONTH: read_word[CCWA_W_MONTH-1:0] = now.month;
            CCWA_OFS_YEAR: read_word[CCWA_W_YEAR-1:0] = now.year;
            CCWA_OFS_CONTROL: read_word[CCWA_CTL_W-1:0] = q.control;
            CCWA_OFS_AL0_MINUTE: read_word[CCWA_W_MIN-1:0] = q.al0_minute;
            CCWA_OFS_AL0_HOUR: read_word[CCWA_W_HOUR-1:0] = q.al0_hour;
            CCWA_OFS_AL0_WEEKDAY: read_word[CCWA_W_WEEK-1:0] = q.al0_weekday;
            CCWA_OFS_AL1_MINUTE: read_word[CCWA_W_MIN-1:0] = q.al1_minute;
            CCWA_OFS_AL1_HOUR: read_word[CCWA_W_HOUR-1:0] = q.al1_hour;
            CCWA_OFS_AL1_DAY: read_word[CCWA_W_DAY-1:0] = q.al1_day;
            CCWA_OFS_AL1_MONTH: read_word[CCWA_W_MONTH-1:0] = q.al1_month;
            CCWA_OFS_TIME_SNAP: read_word = {8'h00, 2'b00, now.hour, 1'b0, now.minute, 1'b0, now.second};
            CCWA_OFS_DATE_SNAP: read_word = {now.year, 3'b000, now.month, 2'b00, now.day, 5'b00000, now.weekday};
            CCWA_OFS_IRQ_STATUS: read_word[CCWA_ST_W-1:0] = q.status;
            default: read_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_q = q;
        // Read data is captured in the setup phase, one coherent snapshot per access
        if (psel && !penable) begin
            next_q.rdata = read_word;
        end
        if (wr) begin
            case (paddr)
                CCWA_OFS_CONTROL: next_q.control = pwdata[CCWA_CTL_W-1:0];
                CCWA_OFS_AL0_MINUTE: next_q.al0_minute = pwdata[CCWA_W_MIN-1:0];
                CCWA_OFS_AL0_HOUR: next_q.al0_hour = pwdata[CCWA_W_HOUR-1:0];
                CCWA_OFS_AL0_WEEKDAY: next_q.al0_weekday = pwdata[CCWA_W_WEEK-1:0];
                CCWA_OFS_AL1_MINUTE: next_q.al1_minute = pwdata[CCWA_W_MIN-1:0];
                CCWA_OFS_AL1_HOUR: next_q.al1_hour = pwdata[CCWA_W_HOUR-1:0];
                CCWA_OFS_AL1_DAY: next_q.al1_day = pwdata[CCWA_W_DAY-1:0];
                CCWA_OFS_AL1_MONTH: next_q.al1_month = pwdata[CCWA_W_MONTH-1:0];
                CCWA_OFS_IRQ_STATUS: next_q.status = q.status & ~pwdata[CCWA_ST_W-1:0];
                default: next_q.control = q.control;
            endcase
        end
        // Alarms fire once on entering the match, not every cycle of it
        next_q.al0_match_prev = al0_match;
        next_q.al1_match_prev = al1_match;
        next_q.periodic_event = periodic_hit;
        next_q.alarm0_event = al0_match && !q.al0_match_prev;
        next_q.alarm1_event = al1_match && !q.al1_match_prev;
        // New events win over a simultaneous write-one clear
        if (periodic_hit) begin
            next_q.status[CCWA_ST_PERIODIC] = 1'b1;
        end
        if (al0_match && !q.al0_match_prev) begin
            next_q.status[CCWA_ST_ALARM0] = 1'b1;
        end
        if (al1_match && !q.al1_match_prev) begin
            next_q.status[CCWA_ST_ALARM1] = 1'b1;
        end
    end

    // The only reset reaching this block is power-on; others leave it running
    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= next_q;
        end
    end

    assign prdata = q.rdata;
    assign periodic_event = q.periodic_event;
    assign alarm0_event = q.alarm0_event;
    assign alarm1_event = q.alarm1_event;

endmodule : ccwa_calendar_clock

// >>> tb/ccwa_calendar_clock_asserts.sv
`timescale 1ns/1ps
module ccwa_calendar_clock_chk
    import ccwa_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic low_speed_tick,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CCWA_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic periodic_event,
    input wire logic alarm0_event,
    input wire logic alarm1_event
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic access;
    logic mapped;
    logic snap;
    assign access = psel && penable;
    assign mapped = paddr[1:0] == 2'h0 && (paddr <= CCWA_OFS_AL1_MONTH || paddr == CCWA_OFS_TIME_SNAP
        || paddr == CCWA_OFS_DATE_SNAP || paddr == CCWA_OFS_IRQ_STATUS);
    assign snap = paddr == CCWA_OFS_TIME_SNAP || paddr == CCWA_OFS_DATE_SNAP;
    access_ready_a: assert property (access |-> pready)
        else $error("access phase without ready");
    unmapped_err_a: assert property (access && paddr[1:0] == 2'h0 && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    mapped_read_a: assert property (access && !pwrite && mapped |-> !pslverr)
        else $error("mapped read refused");
    snap_write_a: assert property (access && pwrite && snap |-> pslverr)
        else $error("snapshot write not refused");
    idle_err_a: assert property (!access |-> !pslverr)
        else $error("error outside access phase");
    read_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data changed without setup");
    periodic_pulse_a: assert property (periodic_event && ce |=> !periodic_event)
        else $error("periodic event longer than one cycle");
    periodic_cause_a: assert property ($rose(periodic_event) |-> $past(low_speed_tick) || $past(low_speed_tick, 2))
        else $error("periodic event without a tick");
    alarm0_pulse_a: assert property (alarm0_event && ce |=> !alarm0_event)
        else $error("alarm 0 event longer than one cycle");
    alarm1_pulse_a: assert property (alarm1_event && ce |=> !alarm1_event)
        else $error("alarm 1 event longer than one cycle");
    reset_clear_a: assert property ($fell(rst) && $past(ce) |->
        prdata == 32'h0 && !periodic_event && !alarm0_event && !alarm1_event)
        else $error("outputs not cleared by reset");
    cover property (periodic_event);
    cover property (alarm0_event);
    cover property (alarm1_event);
    cover property (access && pslverr);
endmodule : ccwa_calendar_clock_chk

bind ccwa_calendar_clock ccwa_calendar_clock_chk i_chk (.clock(clock), .rst(rst), .ce(ce),
    .low_speed_tick(low_speed_tick), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .periodic_event(periodic_event),
    .alarm0_event(alarm0_event), .alarm1_event(alarm1_event));

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import ccwa_pkg::*;
    logic clock = 1'b0, rst = 1'b1, ce = 1'b1, low_speed_tick = 1'b0, tick_en = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, pready, pslverr;
    logic periodic_event, alarm0_event, alarm1_event;
    logic [CCWA_AW-1:0] paddr = 12'h000, a;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0] phase = 2'h0;
    logic [71:0] e;
    // Weekday, day, month, year, expected date view, expected status
    logic [71:0] tbl [5] = '{72'h07_28_02_24_2402_2901_07, 72'h01_29_02_24_2403_0102_01,
        72'h06_28_02_23_2303_0107_01, 72'h07_31_12_99_0001_0101_03, 72'h02_30_04_25_2505_0103_01};
    int n_fail = 0, samples_checked = 0, i, k, t;
    ccwa_calendar_clock #(.PRESCALE_DIV(4)) i_dut (.clock(clock), .rst(rst), .ce(ce),
        .low_speed_tick(low_speed_tick), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periodic_event(periodic_event), .alarm0_event(alarm0_event), .alarm1_event(alarm1_event));
    initial forever #2.5 clock = ~clock;
    // Low-speed tick every fourth cycle; gated off while loading time
    always @(posedge clock) begin
        phase <= phase + 2'h1;
        low_speed_tick <= tick_en && phase == 2'h3;
    end
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic rd_chk(input logic [11:0] ad, input logic [31:0] exp);
        xfer(1'b0, ad, 32'h0);
        chk(rd, exp);
    endtask : rd_chk
    // Loads s at 23:59 and counts ticks up to the first periodic event
    task automatic load(input logic [7:0] s, wk, d, m, y, input logic [31:0] ctl);
        tick_en <= 1'b0;
        xfer(1'b1, CCWA_OFS_CONTROL, 32'h0);
        xfer(1'b1, CCWA_OFS_SECONDS, {24'h0, s});
        xfer(1'b1, CCWA_OFS_MINUTES, 32'h59);
        xfer(1'b1, CCWA_OFS_HOURS, 32'h23);
        xfer(1'b1, CCWA_OFS_WEEKDAY, {24'h0, wk});
        xfer(1'b1, CCWA_OFS_DAY, {24'h0, d});
        xfer(1'b1, CCWA_OFS_MONTH, {24'h0, m});
        xfer(1'b1, CCWA_OFS_YEAR, {24'h0, y});
        xfer(1'b1, CCWA_OFS_CONTROL, ctl);
        tick_en <= 1'b1;
        t = 0;
        for (k = 0; k < 400 && periodic_event !== 1'b1; k++) begin
            if (low_speed_tick === 1'b1)
                t++;
            @(posedge clock);
        end
        tick_en <= 1'b0;
        if (k >= 400) begin
            n_fail++;
            final_report();
        end
    endtask : load
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        for (a = 12'h000; a <= 12'h060; a += 12'h004) begin
            xfer(1'b0, a, 32'h0);
            chk({31'h0, err}, {31'h0, (a > 12'h038 && a < 12'h050) || a == 12'h058 || a == 12'h05C});
            chk(rd, a == 12'h00C ? 32'h7 : a == 12'h010 || a == 12'h014 ? 32'h1 :
                a == 12'h054 ? 32'h0001_0107 : 32'h0);
        end
        xfer(1'b1, CCWA_OFS_SECONDS, 32'hFFFF_FF59);
        rd_chk(CCWA_OFS_SECONDS, 32'h59);
        rd_chk(CCWA_OFS_SECONDS, 32'h59);
        xfer(1'b1, CCWA_OFS_MINUTES, 32'hFFFF_FF45);
        rd_chk(CCWA_OFS_MINUTES, 32'h45);
        xfer(1'b1, CCWA_OFS_CONTROL, 32'hFFFF_FFE0);
        rd_chk(CCWA_OFS_CONTROL, 32'h0);
        xfer(1'b1, CCWA_OFS_TIME_SNAP, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h1);
        rd_chk(CCWA_OFS_TIME_SNAP, 32'h0000_4559);
        for (i = 1; i <= 3; i++) begin
            load(8'h58, 8'h07, 8'h01, 8'h01, 8'h00, 32'(i * 2 + 1));
            chk(32'(t), 32'(2 << (i - 1)));
        end
        xfer(1'b1, CCWA_OFS_IRQ_STATUS, 32'h7);
        xfer(1'b1, CCWA_OFS_AL0_WEEKDAY, 32'h1);
        xfer(1'b1, CCWA_OFS_AL1_DAY, 32'h29);
        xfer(1'b1, CCWA_OFS_AL1_MONTH, 32'h2);
        for (i = 0; i < 5; i++) begin
            e = tbl[i];
            load(8'h59, e[71:64], e[63:56], e[55:48], e[47:40], 32'h1D);
            chk(32'(t), 32'h4);
            // Alarm pulses stand one cycle after the rollover edge
            @(posedge clock);
            chk({30'h0, alarm1_event, alarm0_event}, {30'h0, e[2:1]});
            rd_chk(CCWA_OFS_SECONDS, 32'h0);
            rd_chk(CCWA_OFS_TIME_SNAP, 32'h0);
            rd_chk(CCWA_OFS_DATE_SNAP, e[39:8]);
            rd_chk(CCWA_OFS_IRQ_STATUS, {24'h0, e[7:0]});
            xfer(1'b1, CCWA_OFS_IRQ_STATUS, 32'h7);
        end
        final_report();
    end
endmodule : testbench
